// File: fsp_sequencer.sv
// Flash self-program sequencer: constants package and top module
// Summary of operation
// [R1] Low table read/write reaches word bits 15..0, word or byte mode.
// [R2] High table read/write reaches word bits 23..16, word or byte mode; a byte-mode high write at an odd address writes no lane.
// [R3] Program address is table page low byte joined to effective address.
// [R4] Rows hold 32 instructions; erase and program act on one whole row.
// [R5] Panels hold 128 rows; software moves the table pointer per panel.
// [R6] Each panel has 32 write latches, filled ascending from instruction zero.
// [R7] Software loads latch words from one 32-aligned instruction group only.
// [R8] Table writes take two cycles and only touch the write latches.
// [R9] One program cycle commits exactly one row of latched data.
// [R10] Low address register captures effective address bits 15..0; selects row.
// [R11] High address register captures effective address bits 23..16.
// [R12] Software may write both address registers directly as the target.
// [R13] Key register is write-only; 0x55 then 0xAA must precede a start.
// [R14] Write-start bit 15 launches the operation; hardware clears it when done.
// [R15] Operations last nominally 2 ms with the processor stalled throughout.
// [R16] Erase setup: multi-word erase op with write enable, address, keys, start.
// [R17] Program setup: fill latches, program op with write enable, keys, start.
// [R18] A full row load takes 32 low and 32 high table writes.
// [R19] Software masks interrupts below 7 for five instructions around unlock.
// [R20] Software follows the write-start with two no-operation instructions.
// [R21] Start ignored unless the last two key writes were the pair in order.
// [R22] Start with write enable clear launches nothing and leaves flash alone.
package fsp_pkg;
  localparam logic [15:0] ADR_CTRL = 16'h0970;
  localparam logic [15:0] ADR_LOW = 16'h0762;
  localparam logic [15:0] ADR_HIGH = 16'h0764;
  localparam logic [15:0] ADR_KEY = 16'h0766;
  localparam int CTRL_WR_BIT = 15;
  localparam int CTRL_WE_BIT = 14;
  localparam int CTRL_ERR_BIT = 13;
  localparam int OP_W = 7;
  localparam logic [6:0] OP_ERASE_ROW = 7'h41;
  localparam logic [6:0] OP_PROG_ROW = 7'h01;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] ADR_RESET = 16'h0000;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam int ROW_WORDS = 32;
  localparam int IDX_W = 5;
  localparam int ROW_LSB = 6;
  localparam int PANEL_ROWS = 128;
  localparam int CLK_MHZ = 40;
  localparam int OP_TIME_US = 2000;
  localparam int OP_CYCLES = OP_TIME_US * CLK_MHZ;
  localparam int TMR_W = 20;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ERASE = 4'h2,
    ST_PROG = 4'h4,
    ST_WAIT = 4'h8
  } fsp_state_t;
  typedef enum logic [2:0] {
    KEY_IDLE = 3'h1,
    KEY_HALF = 3'h2,
    KEY_ARMED = 3'h4
  } fsp_key_t;
  // Byte lanes of a latch word touched by one table write
  function automatic logic [2:0] lane_mask(input logic high, input logic byte_mode, input logic odd);
    if (high) begin
      lane_mask = (byte_mode && odd) ? 3'h0 : 3'h4;
    end else if (byte_mode) begin
      lane_mask = odd ? 3'h2 : 3'h1;
    end else begin
      lane_mask = 3'h3;
    end
  endfunction : lane_mask
endpackage : fsp_pkg

`timescale 1ns/1ps
module fsp_sequencer #(
  parameter int unsigned OP_CYCLES = fsp_pkg::OP_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Table instruction port
  input wire logic tbl_valid_i,
  input wire logic tbl_write_i,
  input wire logic tbl_high_i,
  input wire logic tbl_byte_i,
  input wire logic [15:0] tbl_eff_addr_i,
  input wire logic [7:0] tbl_page_i,
  input wire logic [15:0] tbl_wdata_i,
  output logic [15:0] tbl_rdata_o,
  output logic tbl_done_o,
  // Register port
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [15:0] sfr_addr_i,
  input wire logic [15:0] sfr_wdata_i,
  output logic [15:0] sfr_rdata_o,
  // Flash array
  output logic flash_rd_o,
  output logic [23:0] flash_raddr_o,
  input wire logic [23:0] flash_rdata_i,
  output logic flash_erase_o,
  output logic flash_wr_o,
  output logic [23:0] flash_waddr_o,
  output logic [23:0] flash_wdata_o,
  // Processor
  output logic cpu_stall_o
);
  fsp_pkg::fsp_state_t state_reg;
  fsp_pkg::fsp_key_t key_reg;
  logic [15:0] adr_low_reg;
  logic [7:0] adr_high_reg;
  logic wr_reg, wr_enable_reg, err_reg;
  logic [6:0] op_reg;
  logic [fsp_pkg::TMR_W-1:0] tmr_reg;
  logic [fsp_pkg::IDX_W-1:0] idx_reg;
  logic [23:0] row_reg;
  logic rd_pend_reg, rd_high_reg, rd_byte_reg, rd_odd_reg, rd_done_reg, wr_done_reg;
  logic busy, tbl_take, lat_we;
  logic [2:0] lat_mask;
  logic [23:0] lat_wdata;
  logic ctrl_wr, key_wr, start_ok, start, op_bad, op_done;

  assign busy = (state_reg != fsp_pkg::ST_IDLE);
  assign cpu_stall_o = busy; // R15
  // Reads in flight block a new request so the answer cannot be overtaken
  assign tbl_take = tbl_valid_i && !busy && !rd_pend_reg && !flash_rd_o;
  assign lat_we = tbl_take && tbl_write_i; // R8
  assign lat_mask = fsp_pkg::lane_mask(tbl_high_i, tbl_byte_i, tbl_eff_addr_i[0]); // R1 R2
  assign lat_wdata = tbl_high_i ? {tbl_wdata_i[7:0], 16'h0000} :
                     (tbl_byte_i ? {8'h00, tbl_wdata_i[7:0], tbl_wdata_i[7:0]} : {8'h00, tbl_wdata_i});
  assign ctrl_wr = sfr_wr_i && !busy && (sfr_addr_i == fsp_pkg::ADR_CTRL);
  assign key_wr = sfr_wr_i && !busy && (sfr_addr_i == fsp_pkg::ADR_KEY);
  assign start_ok = ctrl_wr && sfr_wdata_i[fsp_pkg::CTRL_WR_BIT] && (key_reg == fsp_pkg::KEY_ARMED)
                    && sfr_wdata_i[fsp_pkg::CTRL_WE_BIT]; // R21 R22
  assign start = start_ok && (sfr_wdata_i[6:0] == fsp_pkg::OP_ERASE_ROW ||
                              sfr_wdata_i[6:0] == fsp_pkg::OP_PROG_ROW);
  assign op_bad = start_ok && !start;
  assign op_done = (state_reg == fsp_pkg::ST_WAIT) && (tmr_reg == '0);

  // Write latches; every table write lands here and never in the array
  fsp_latch_mem u_latch (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(lat_we),
    .wr_idx_i(tbl_eff_addr_i[5:1]),
    .wr_mask_i(lat_mask),
    .wr_data_i(lat_wdata),
    .rd_idx_i(idx_reg),
    .rd_data_o(flash_wdata_o)
  ); // R6 R8

  // Unlock key tracking
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      key_reg <= fsp_pkg::KEY_IDLE;
    end else if (key_wr) begin
      if (sfr_wdata_i[7:0] == fsp_pkg::KEY_FIRST) begin // R13
        key_reg <= fsp_pkg::KEY_HALF;
      end else if (sfr_wdata_i[7:0] == fsp_pkg::KEY_SECOND && key_reg == fsp_pkg::KEY_HALF) begin
        key_reg <= fsp_pkg::KEY_ARMED;
      end else begin
        key_reg <= fsp_pkg::KEY_IDLE; // R21
      end
    end else if (sfr_wr_i) begin
      // Any other register write breaks the consecutive pair
      key_reg <= fsp_pkg::KEY_IDLE; // R21
    end
  end

  // Control register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_reg <= fsp_pkg::CTRL_RESET[fsp_pkg::CTRL_WR_BIT];
      wr_enable_reg <= fsp_pkg::CTRL_RESET[fsp_pkg::CTRL_WE_BIT];
      err_reg <= fsp_pkg::CTRL_RESET[fsp_pkg::CTRL_ERR_BIT];
      op_reg <= fsp_pkg::CTRL_RESET[6:0];
    end else begin
      if (ctrl_wr) begin
        wr_enable_reg <= sfr_wdata_i[fsp_pkg::CTRL_WE_BIT];
        op_reg <= sfr_wdata_i[6:0];
      end
      if (start) begin
        wr_reg <= 1'b1; // R14
      end else if (op_done) begin
        wr_reg <= 1'b0; // R14
      end
      // Hardware set beats a software clear in the same cycle
      if (op_bad) begin
        err_reg <= 1'b1;
      end else if (ctrl_wr) begin
        err_reg <= sfr_wdata_i[fsp_pkg::CTRL_ERR_BIT];
      end
    end
  end

  // Address capture registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      adr_low_reg <= fsp_pkg::ADR_RESET;
      adr_high_reg <= fsp_pkg::ADR_RESET[7:0];
    end else if (sfr_wr_i && !busy && sfr_addr_i == fsp_pkg::ADR_LOW) begin
      adr_low_reg <= sfr_wdata_i; // R12
    end else if (sfr_wr_i && !busy && sfr_addr_i == fsp_pkg::ADR_HIGH) begin
      adr_high_reg <= sfr_wdata_i[7:0]; // R12
    end else if (tbl_take) begin
      adr_low_reg <= tbl_eff_addr_i; // R10
      adr_high_reg <= tbl_page_i; // R11
    end
  end

  // Register read data; key reads as zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sfr_rdata_o <= 16'h0000;
    end else if (sfr_rd_i) begin
      unique case (sfr_addr_i)
        fsp_pkg::ADR_CTRL: sfr_rdata_o <= {wr_reg, wr_enable_reg, err_reg, 6'h00, op_reg};
        fsp_pkg::ADR_LOW: sfr_rdata_o <= adr_low_reg;
        fsp_pkg::ADR_HIGH: sfr_rdata_o <= {8'h00, adr_high_reg};
        default: sfr_rdata_o <= 16'h0000;
      endcase
    end
  end

  // Table read path: address out one cycle after take, strobe one later, answer one after that
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_pend_reg <= 1'b0;
      rd_high_reg <= 1'b0;
      rd_byte_reg <= 1'b0;
      rd_odd_reg <= 1'b0;
      flash_rd_o <= 1'b0;
      flash_raddr_o <= 24'h000000;
      rd_done_reg <= 1'b0;
      wr_done_reg <= 1'b0;
      tbl_rdata_o <= 16'h0000;
    end else begin
      rd_pend_reg <= tbl_take && !tbl_write_i;
      flash_rd_o <= rd_pend_reg;
      rd_done_reg <= flash_rd_o;
      wr_done_reg <= lat_we; // R8
      if (tbl_take) begin
        rd_high_reg <= tbl_high_i;
        rd_byte_reg <= tbl_byte_i;
        rd_odd_reg <= tbl_eff_addr_i[0];
        flash_raddr_o <= {tbl_page_i, tbl_eff_addr_i}; // R3 R5
      end
      if (flash_rd_o) begin
        if (rd_high_reg) begin
          tbl_rdata_o <= {8'h00, flash_rdata_i[23:16]}; // R2
        end else if (rd_byte_reg && rd_odd_reg) begin
          tbl_rdata_o <= {8'h00, flash_rdata_i[15:8]}; // R1
        end else if (rd_byte_reg) begin
          tbl_rdata_o <= {8'h00, flash_rdata_i[7:0]}; // R1
        end else begin
          tbl_rdata_o <= flash_rdata_i[15:0]; // R1
        end
      end
    end
  end
  assign tbl_done_o = rd_done_reg || wr_done_reg;

  // Operation sequencer
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= fsp_pkg::ST_IDLE;
      tmr_reg <= '0;
      idx_reg <= '0;
      row_reg <= 24'h000000;
    end else begin
      unique case (state_reg)
        fsp_pkg::ST_IDLE: begin
          idx_reg <= '0;
          if (start) begin
            // Row is taken from the captured address, low bits dropped
            row_reg <= {adr_high_reg, adr_low_reg[15:fsp_pkg::ROW_LSB], 6'h00}; // R4 R10
            tmr_reg <= fsp_pkg::TMR_W'(OP_CYCLES - 1); // R15
            state_reg <= (sfr_wdata_i[6:0] == fsp_pkg::OP_ERASE_ROW) ? fsp_pkg::ST_ERASE : fsp_pkg::ST_PROG;
          end
        end
        fsp_pkg::ST_ERASE: begin
          tmr_reg <= tmr_reg - 1'b1;
          state_reg <= fsp_pkg::ST_WAIT;
        end
        fsp_pkg::ST_PROG: begin
          tmr_reg <= tmr_reg - 1'b1;
          idx_reg <= idx_reg + 1'b1;
          if (idx_reg == fsp_pkg::IDX_W'(fsp_pkg::ROW_WORDS - 1)) begin
            state_reg <= fsp_pkg::ST_WAIT; // R9
          end
        end
        fsp_pkg::ST_WAIT: begin
          if (tmr_reg == '0) begin
            state_reg <= fsp_pkg::ST_IDLE; // R15
          end else begin
            tmr_reg <= tmr_reg - 1'b1;
          end
        end
        default: state_reg <= fsp_pkg::ST_IDLE;
      endcase
    end
  end

  // Array strobes line up with the registered latch read data
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flash_erase_o <= 1'b0;
      flash_wr_o <= 1'b0;
      flash_waddr_o <= 24'h000000;
    end else begin
      flash_erase_o <= (state_reg == fsp_pkg::ST_ERASE); // R4
      flash_wr_o <= (state_reg == fsp_pkg::ST_PROG); // R4 R9
      if (state_reg == fsp_pkg::ST_PROG) begin
        flash_waddr_o <= {row_reg[23:fsp_pkg::ROW_LSB], idx_reg, 1'b0};
      end else if (state_reg == fsp_pkg::ST_ERASE) begin
        flash_waddr_o <= row_reg;
      end
    end
  end

  // Checking helpers
  logic [fsp_pkg::TMR_W-1:0] stall_cnt;
  logic [5:0] wr_cnt;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stall_cnt <= '0;
      wr_cnt <= '0;
    end else begin
      stall_cnt <= busy ? stall_cnt + 1'b1 : '0;
      wr_cnt <= busy ? wr_cnt + 6'(flash_wr_o) : '0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_key_pair;
    key_wr && sfr_wdata_i[7:0] == fsp_pkg::KEY_FIRST ##1 key_wr && sfr_wdata_i[7:0] == fsp_pkg::KEY_SECOND;
  endsequence
  sequence s_start_req;
    ctrl_wr && sfr_wdata_i[fsp_pkg::CTRL_WR_BIT] && sfr_wdata_i[fsp_pkg::CTRL_WE_BIT]
      && sfr_wdata_i[6:0] == fsp_pkg::OP_ERASE_ROW;
  endsequence

  a_low_read_word: assert property (flash_rd_o && !rd_high_reg && !rd_byte_reg |=> // R1
    tbl_done_o && tbl_rdata_o == $past(flash_rdata_i[15:0])) else $error("low read data wrong");
  a_high_read_byte: assert property (flash_rd_o && rd_high_reg |=> // R2
    tbl_done_o && tbl_rdata_o == {8'h00, $past(flash_rdata_i[23:16])}) else $error("high read data wrong");
  a_read_addr_form: assert property (tbl_take && !tbl_write_i |=> ##0 !flash_rd_o ##1 // R3
    flash_rd_o && flash_raddr_o == {$past(tbl_page_i, 2), $past(tbl_eff_addr_i, 2)}) else $error("read address wrong");
  a_write_two_cycle: assert property (tbl_take && tbl_write_i |=> tbl_done_o && !flash_wr_o) // R8
    else $error("table write timing wrong");
  a_addr_capture: assert property (tbl_take && !sfr_wr_i |=> // R10 R11
    adr_low_reg == $past(tbl_eff_addr_i) && adr_high_reg == $past(tbl_page_i)) else $error("address not captured");
  a_addr_direct: assert property (sfr_wr_i && !busy && sfr_addr_i == fsp_pkg::ADR_LOW |=> // R12
    adr_low_reg == $past(sfr_wdata_i)) else $error("direct address write lost");
  a_unlock_start: assert property (s_key_pair ##1 s_start_req |=> cpu_stall_o && wr_reg) // R13
    else $error("unlocked start did not launch");
  a_start_needs_key: assert property ($rose(wr_reg) |-> $past(key_reg) == fsp_pkg::KEY_ARMED) // R21
    else $error("start without unlock");
  a_no_enable_start: assert property (ctrl_wr && !sfr_wdata_i[fsp_pkg::CTRL_WE_BIT] |=> // R22
    !cpu_stall_o && !wr_reg && !flash_erase_o ##1 !flash_erase_o && !flash_wr_o) else $error("start without enable");
  a_stall_length: assert property ($fell(cpu_stall_o) |-> stall_cnt == fsp_pkg::TMR_W'(OP_CYCLES)) // R15
    else $error("stall length wrong");
  a_wr_autoclear: assert property (op_done |=> !wr_reg && !cpu_stall_o) // R14
    else $error("write bit not cleared");
  a_row_words: assert property ($fell(cpu_stall_o) && op_reg == fsp_pkg::OP_PROG_ROW |-> // R4 R9
    $past(wr_cnt) == 6'(fsp_pkg::ROW_WORDS)) else $error("row word count wrong");
endmodule : fsp_sequencer

// File: fsp_latch_mem.sv
// Row write latch memory with byte lanes and registered read
`timescale 1ns/1ps
module fsp_latch_mem (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Write side
  input wire logic wr_en_i,
  input wire logic [4:0] wr_idx_i,
  input wire logic [2:0] wr_mask_i,
  input wire logic [23:0] wr_data_i,
  // Read side
  input wire logic [4:0] rd_idx_i,
  output logic [23:0] rd_data_o
);
  // No reset on the array; software fills it before every program cycle
  logic [23:0] mem [0:31];

  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 3; i++) begin
      if (wr_en_i && wr_mask_i[i]) begin
        mem[wr_idx_i][i*8 +: 8] <= wr_data_i[i*8 +: 8]; // R6
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= 24'h000000;
    end else begin
      rd_data_o <= mem[rd_idx_i];
    end
  end
endmodule : fsp_latch_mem

// File: fsp_flash_model.sv
// Behavioural program flash array facing the sequencer
`timescale 1ns/1ps
module fsp_flash_model (
  // Clock
  input wire logic clk_i,
  // Read port
  input wire logic rd_i,
  input wire logic [23:0] raddr_i,
  output logic [23:0] rdata_o,
  // Erase and program port
  input wire logic erase_i,
  input wire logic wr_i,
  input wire logic [23:0] waddr_i,
  input wire logic [23:0] wdata_i
);
  logic [23:0] mem [0:255];
  logic [23:0] last_q;
  logic [23:0] last_a;
  int erases;
  int writes;
  // Off-read data is the inverse of the last word, so stale sampling shows
  assign rdata_o = rd_i ? mem[raddr_i[8:1]] : ~last_q;
  initial begin
    last_q = 24'h0;
    last_a = 24'h0;
    erases = 0;
    writes = 0;
    foreach (mem[i]) mem[i] = 24'hffffff;
  end
  always @(posedge clk_i) begin
    if (rd_i) begin
      last_q <= mem[raddr_i[8:1]];
      last_a <= raddr_i;
    end
    if (erase_i) begin
      erases <= erases + 1;
      for (int i = 0; i < 32; i++) begin
        mem[{waddr_i[8:6], i[4:0]}] <= 24'hffffff;
      end
    end
    if (wr_i) begin
      writes <= writes + 1;
      // Programming only clears bits, as a real cell does
      mem[waddr_i[8:1]] <= mem[waddr_i[8:1]] & wdata_i;
    end
  end
endmodule : fsp_flash_model

// File: fsp_sequencer_bench.sv
// Self-checking bench for the flash self-program sequencer
`timescale 1ns/1ps
module fsp_sequencer_bench;
  // Shortened operation time keeps the run brief
  localparam int OPC = 64;
  logic clk_i, rst_i, tbl_valid_i, tbl_write_i, tbl_high_i, tbl_byte_i, tbl_done_o;
  logic sfr_wr_i, sfr_rd_i, flash_rd_o, flash_erase_o, flash_wr_o, cpu_stall_o;
  logic [15:0] tbl_eff_addr_i, tbl_wdata_i, tbl_rdata_o, sfr_addr_i, sfr_wdata_i, sfr_rdata_o, r;
  logic [7:0] tbl_page_i;
  logic [23:0] flash_raddr_o, flash_rdata_i, flash_waddr_o, flash_wdata_o;
  logic [15:0] adrs [5];
  int failures = 0;
  int checked = 0;
  int n;
  fsp_sequencer #(.OP_CYCLES(OPC)) uut (.clk_i(clk_i), .rst_i(rst_i), .tbl_valid_i(tbl_valid_i),
    .tbl_write_i(tbl_write_i), .tbl_high_i(tbl_high_i), .tbl_byte_i(tbl_byte_i), .tbl_eff_addr_i(tbl_eff_addr_i),
    .tbl_page_i(tbl_page_i), .tbl_wdata_i(tbl_wdata_i), .tbl_rdata_o(tbl_rdata_o), .tbl_done_o(tbl_done_o),
    .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .flash_rd_o(flash_rd_o), .flash_raddr_o(flash_raddr_o),
    .flash_rdata_i(flash_rdata_i), .flash_erase_o(flash_erase_o), .flash_wr_o(flash_wr_o),
    .flash_waddr_o(flash_waddr_o), .flash_wdata_o(flash_wdata_o), .cpu_stall_o(cpu_stall_o));
  fsp_flash_model fm (.clk_i(clk_i), .rd_i(flash_rd_o), .raddr_i(flash_raddr_o), .rdata_o(flash_rdata_i),
    .erase_i(flash_erase_o), .wr_i(flash_wr_o), .waddr_i(flash_waddr_o), .wdata_i(flash_wdata_o));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic end_of_test;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic tick;
    @(posedge clk_i);
    #2;
  endtask : tick
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  function automatic logic [15:0] slot_addr(input int i);
    return 16'h0080 + 16'(2 * i);
  endfunction : slot_addr
  // A strobe left high by more keeps writes back to back
  task automatic sw(input logic [15:0] a, input logic [15:0] d, input bit more);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    tick;
    if (!more) begin
      sfr_wr_i = 1'b0;
      tick;
    end
  endtask : sw
  task automatic sr(input logic [15:0] a, output logic [15:0] d);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    tick;
    sfr_rd_i = 1'b0;
    d = sfr_rdata_o;
    tick;
  endtask : sr
  task automatic tb(input logic w, input logic h, input logic b, input logic [15:0] e, input logic [7:0] pg,
      input logic [15:0] wd, output logic [15:0] rd);
    int k;
    k = 0;
    tbl_write_i = w;
    tbl_high_i = h;
    tbl_byte_i = b;
    tbl_eff_addr_i = e;
    tbl_page_i = pg;
    tbl_wdata_i = wd;
    tbl_valid_i = 1'b1;
    tick;
    while (tbl_done_o !== 1'b1 && k < 20) begin
      k++;
      tick;
    end
    if (k == 20) begin
      chk("table done", 24'h1, 24'h0);
      end_of_test;
    end
    tbl_valid_i = 1'b0;
    rd = tbl_rdata_o;
    tick;
  endtask : tb
  task automatic start(input logic [15:0] k1, input logic [15:0] k2, input logic [15:0] c, output int cnt);
    sw(fsp_pkg::ADR_KEY, k1, 1);
    sw(fsp_pkg::ADR_KEY, k2, 1);
    sw(fsp_pkg::ADR_CTRL, c, 1);
    sfr_wr_i = 1'b0;
    cnt = 0;
    while (cpu_stall_o === 1'b1 && cnt < 1000) begin
      cnt++;
      tick;
    end
    if (cnt == 1000) begin
      chk("stall end", 24'h0, 24'h1);
      end_of_test;
    end
    tick;
  endtask : start
  initial begin
    {tbl_valid_i, tbl_write_i, tbl_high_i, tbl_byte_i, sfr_wr_i, sfr_rd_i} = 6'h00;
    {tbl_eff_addr_i, tbl_wdata_i, sfr_addr_i, sfr_wdata_i, tbl_page_i} = 72'h0;
    rst_i = 1'b1;
    adrs = '{fsp_pkg::ADR_CTRL, fsp_pkg::ADR_LOW, fsp_pkg::ADR_HIGH, fsp_pkg::ADR_KEY, 16'h0800};
    repeat (6) @(posedge clk_i);
    #2;
    rst_i = 1'b0;
    foreach (adrs[i]) begin
      sr(adrs[i], r);
      chk("reset or key read", 24'h0, 24'(r));
    end
    sw(fsp_pkg::ADR_LOW, 16'h1234, 0);
    sw(fsp_pkg::ADR_HIGH, 16'hffab, 0);
    sr(fsp_pkg::ADR_LOW, r);
    chk("addr low", 24'h1234, 24'(r));
    sr(fsp_pkg::ADR_HIGH, r);
    chk("addr high", 24'h00ab, 24'(r));
    for (int i = 0; i < 32; i++) begin
      tb(1, 0, 0, slot_addr(i), 8'h00, 16'h1000 + 16'(i), r);
      tb(1, 1, 0, slot_addr(i), 8'h00, 16'h0020 + 16'(i), r);
    end
    tb(1, 0, 1, 16'h0081, 8'h00, 16'h005a, r);
    tb(1, 1, 1, 16'h0083, 8'h00, 16'h0077, r);
    chk("flash untouched", 24'h0, 24'(fm.writes));
    start(16'h00aa, 16'h0055, 16'hc001, n);
    chk("bad key stall", 24'h0, 24'(n));
    start(16'h0055, 16'h00aa, 16'h8001, n);
    chk("no enable stall", 24'h0, 24'(n));
    chk("no enable writes", 24'h0, 24'(fm.writes));
    start(16'h0055, 16'h00aa, 16'hc001, n);
    chk("program stall", 24'(OPC), 24'(n));
    chk("program words", 24'd32, 24'(fm.writes));
    sr(fsp_pkg::ADR_CTRL, r);
    chk("start bit clear", 24'h0, 24'(r[15]));
    for (int i = 0; i < 32; i++) begin
      tb(0, 0, 0, slot_addr(i), 8'h00, 16'h0, r);
      chk("low word", (i == 0) ? 24'h5a00 : 24'h1000 + 24'(i), 24'(r));
      tb(0, 1, 0, slot_addr(i), 8'h00, 16'h0, r);
      chk("high byte", 24'h20 + 24'(i), 24'(r));
    end
    tb(0, 0, 1, 16'h0081, 8'h00, 16'h0, r);
    chk("odd byte read", 24'h005a, 24'(r));
    tb(0, 0, 1, 16'h0082, 8'h00, 16'h0, r);
    chk("even byte read", 24'h0001, 24'(r));
    tb(0, 0, 0, 16'h0042, 8'h03, 16'h0, r);
    chk("read address", 24'h030042, fm.last_a);
    sr(fsp_pkg::ADR_LOW, r);
    chk("captured low", 24'h0042, 24'(r));
    sr(fsp_pkg::ADR_HIGH, r);
    chk("captured high", 24'h0003, 24'(r));
    start(16'h0055, 16'h00aa, 16'hc07f, n);
    chk("bad op stall", 24'h0, 24'(n));
    sr(fsp_pkg::ADR_CTRL, r);
    chk("error flag", 24'h607f, 24'(r));
    sw(fsp_pkg::ADR_CTRL, 16'h4041, 0);
    sw(fsp_pkg::ADR_HIGH, 16'h0000, 0);
    sw(fsp_pkg::ADR_LOW, 16'h0080, 0);
    start(16'h0055, 16'h00aa, 16'hc041, n);
    chk("erase stall", 24'(OPC), 24'(n));
    chk("erase count", 24'h1, 24'(fm.erases));
    tb(0, 0, 0, slot_addr(31), 8'h00, 16'h0, r);
    chk("erased low", 24'hffff, 24'(r));
    tb(0, 1, 0, slot_addr(0), 8'h00, 16'h0, r);
    chk("erased high", 24'h00ff, 24'(r));
    end_of_test;
  end
endmodule : fsp_sequencer_bench
